// ---- shared/ivm_regs.vh ----
/*
 * Vector numbering and reset values for the interrupt vector mapper.
 * Assumes nothing; definitions only.
 */
`ifndef IVM_REGS_VH
`define IVM_REGS_VH
`define IVM_NUM_VEC        26
`define IVM_VEC_W          5
`define IVM_VEC_RESET      5'h00
`define IVM_VEC_NMI        5'h01
`define IVM_VEC_SUPPLY     5'h02
`define IVM_VEC_PORTA      5'h03
`define IVM_VEC_PORTB      5'h04
`define IVM_VEC_PORTC      5'h05
`define IVM_VEC_RTC        5'h06
`define IVM_VEC_TICK       5'h07
`define IVM_VEC_TA_OVF     5'h08
`define IVM_VEC_TA_HUNF    5'h09
`define IVM_VEC_TA_CMP0    5'h0A
`define IVM_VEC_TA_CMP1    5'h0B
`define IVM_VEC_TA_CMP2    5'h0C
`define IVM_VEC_TB         5'h0D
`define IVM_VEC_TD_OVF     5'h0E
`define IVM_VEC_TD_TRIG    5'h0F
`define IVM_VEC_CMP        5'h10
`define IVM_VEC_ADC_RDY    5'h11
`define IVM_VEC_ADC_WIN    5'h12
`define IVM_VEC_TW_TGT     5'h13
`define IVM_VEC_TW_CTL     5'h14
`define IVM_VEC_SPI        5'h15
`define IVM_VEC_SER_RXC    5'h16
`define IVM_VEC_SER_DRE    5'h17
`define IVM_VEC_SER_TXC    5'h18
`define IVM_VEC_EEPROM     5'h19
`define IVM_RST_FLAG       1'b0
`define IVM_RST_ENABLE     1'b0
`define IVM_RST_NMI        1'b0
`endif

// ---- rtl/ivm_source.v ----
/*
 * One interrupt source: sticky pending flag and its enable bit.
 * Assumes set and clear pulses come from logic on clk.
 */
`default_nettype none
`include "ivm_regs.vh"
module ivm_source (
    input  wire clk,
    input  wire rst_n,
    input  wire clk_en,
    input  wire cond_set,
    input  wire flag_clr,
    input  wire en_wr,
    input  wire en_val,
    output reg  source_pending_flag_ff,
    output reg  source_irq_enable_ff,
    output wire req
);
    wire nxt_flag;
    // Set beats clear so an event in the clearing cycle is kept
    assign nxt_flag = cond_set | (source_pending_flag_ff & ~flag_clr);   // [R2]

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            source_pending_flag_ff <= `IVM_RST_FLAG;
            source_irq_enable_ff   <= `IVM_RST_ENABLE;
        end else if (clk_en) begin
            source_pending_flag_ff <= nxt_flag;                          // [R2]
            if (en_wr) begin
                source_irq_enable_ff <= en_val;                          // [R3]
            end
        end
    end

    // Request holds while both bits stay set
    assign req = source_pending_flag_ff & source_irq_enable_ff;          // [R4]
endmodule // ivm_source
`default_nettype wire

// ---- rtl/ivm_mapper.v ----
/*
 * Interrupt vector mapper: gathers the peripheral interrupt sources onto
 * 26 vectors and presents the lowest pending one to the CPU.
 * Assumes all inputs are synchronous to clk and come from on-chip logic,
 * so none of them passes a synchroniser.
 */
// Behaviour
// (R1) Twenty-six vectors, one peripheral each.
// (R2) Peripheral condition sets its source flag.
// (R3) Software writes each source enable bit.
// (R4) Request while flag and enable set.
// (R5) Global enable gates all maskable requests.
// (R6) Vector 0 reset, 1 unmaskable scan.
// (R7) Vectors 2-5: supply monitor, ports A-C.
// (R8) Vectors 6-7: counter and periodic tick.
// (R9) Vectors 8-12: timer A sources.
// (R10) Vectors 13-15: timer B, timer D.
// (R11) Vectors 16-18: comparator and converter.
// (R12) Vectors 19-21: two-wire and serial peripheral.
// (R13) Vectors 22-25: serial port, eeprom ready.
// (R14) Lowest pending vector presented first.
`default_nettype none
`include "ivm_regs.vh"
module ivm_mapper (
    // Clock, reset and freeze
    input  wire        clk,
    input  wire        rst_n,
    input  wire        clk_en,
    // Global gate and the unmaskable scan line
    input  wire        global_irq_enable,
    input  wire        memory_scan_nonmaskable_irq,
    // Per-source set, clear and enable write from the peripherals
    input  wire [30:0] source_cond,
    input  wire [30:0] source_clr,
    input  wire [30:0] enable_wr,
    input  wire [30:0] enable_val,
    // Accepted but unused: a vector is serviced by clearing its flag
    input  wire        vector_ack,
    // Per-source state read back by the peripherals
    output wire [30:0] source_pending_flag,
    output wire [30:0] source_irq_enable,
    // CPU side
    output wire [25:0] vector_req,
    output wire        irq_valid,
    output reg  [4:0]  irq_vector_ff,
    output reg         nmi_ff
);
    // Source index order (31 sources onto vectors 2..25):
    // 0 supply, 1-3 ports A-C, 4 rtc, 5 tick, 6 ta low underflow, 7 ta overflow,
    // 8 ta high underflow, 9-11 ta compare 0-2, 12 tb, 13 td ovf, 14 td trig,
    // 15 comparator, 16 adc ready, 17 adc window, 18 tw target, 19 tw ctrl,
    // 20 spi, 21 rxc, 22 dre, 23 txc, 24 eeprom, 25-30 spare port-pin sources
    // (26 port A, 27 port B, 28 port C second groups; 25,29,30 reserved idle)
    // Sources 25, 29 and 30 keep working flags but feed no vector
    localparam NUM_SRC = 31;

    wire [30:0] src_req;
    wire [25:0] vec_raw;

    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i = i + 1) begin : g_src
            ivm_source u_src (
                .clk                    (clk),
                .rst_n                  (rst_n),
                .clk_en                 (clk_en),
                .cond_set               (source_cond[i]),
                .flag_clr               (source_clr[i]),
                .en_wr                  (enable_wr[i]),
                .en_val                 (enable_val[i]),
                .source_pending_flag_ff (source_pending_flag[i]),
                .source_irq_enable_ff   (source_irq_enable[i]),
                .req                    (src_req[i])
            );
        end
    endgenerate

    // Vector 0 is the reset entry and never a request
    assign vec_raw[`IVM_VEC_RESET]   = 1'b0;                               // [R6]
    // Scan fault is a level, not latched: it drops when the scan unit drops it
    assign vec_raw[`IVM_VEC_NMI]     = memory_scan_nonmaskable_irq;        // [R6]

    // Supply monitor
    assign vec_raw[`IVM_VEC_SUPPLY]  = src_req[0];                         // [R7]

    // Each port vector takes both of its pin groups
    assign vec_raw[`IVM_VEC_PORTA]   = src_req[1] | src_req[26];           // [R7]
    assign vec_raw[`IVM_VEC_PORTB]   = src_req[2] | src_req[27];           // [R7]
    assign vec_raw[`IVM_VEC_PORTC]   = src_req[3] | src_req[28];           // [R7]

    // Real-time counter: counter match and periodic tick kept apart
    assign vec_raw[`IVM_VEC_RTC]     = src_req[4];                         // [R8]
    assign vec_raw[`IVM_VEC_TICK]    = src_req[5];                         // [R8]

    // Timer A: low underflow and overflow share one vector
    assign vec_raw[`IVM_VEC_TA_OVF]  = src_req[6] | src_req[7];            // [R9]
    assign vec_raw[`IVM_VEC_TA_HUNF] = src_req[8];                         // [R9]

    // Timer A compare channels 0 to 2
    assign vec_raw[`IVM_VEC_TA_CMP0] = src_req[9];                         // [R9]
    assign vec_raw[`IVM_VEC_TA_CMP1] = src_req[10];                        // [R9]
    assign vec_raw[`IVM_VEC_TA_CMP2] = src_req[11];                        // [R9]

    // Timer B, then timer D overflow and trigger
    assign vec_raw[`IVM_VEC_TB]      = src_req[12];                        // [R10]
    assign vec_raw[`IVM_VEC_TD_OVF]  = src_req[13];                        // [R10]
    assign vec_raw[`IVM_VEC_TD_TRIG] = src_req[14];                        // [R10]

    // Analog comparator, then converter result and window
    assign vec_raw[`IVM_VEC_CMP]     = src_req[15];                        // [R11]
    assign vec_raw[`IVM_VEC_ADC_RDY] = src_req[16];                        // [R11]
    assign vec_raw[`IVM_VEC_ADC_WIN] = src_req[17];                        // [R11]

    // Two-wire target and controller, then serial peripheral
    assign vec_raw[`IVM_VEC_TW_TGT]  = src_req[18];                        // [R12]
    assign vec_raw[`IVM_VEC_TW_CTL]  = src_req[19];                        // [R12]
    assign vec_raw[`IVM_VEC_SPI]     = src_req[20];                        // [R12]

    // Serial port receive, data empty and transmit complete
    assign vec_raw[`IVM_VEC_SER_RXC] = src_req[21];                        // [R13]
    assign vec_raw[`IVM_VEC_SER_DRE] = src_req[22];                        // [R13]
    assign vec_raw[`IVM_VEC_SER_TXC] = src_req[23];                        // [R13]

    // Memory controller ready for the next eeprom access
    assign vec_raw[`IVM_VEC_EEPROM]  = src_req[24];                        // [R13]

    // Non-maskable vector bypasses the global enable
    assign vector_req = global_irq_enable ? vec_raw
                      : (vec_raw & (26'h0000001 << `IVM_VEC_NMI));         // [R5] [R6]

    function [4:0] lowest_set;
        input [25:0] v;
        integer k;
        begin
            lowest_set = 5'h00;
            for (k = 25; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    lowest_set = k[4:0];
                end
            end
        end
    endfunction

    wire [4:0] nxt_vector;
    assign nxt_vector = lowest_set(vector_req);                            // [R14]
    assign irq_valid  = |vector_req;                                       // [R1]

    // Registered vector follows the live winner; others wait in their flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_vector_ff <= `IVM_VEC_RESET;
        end else if (clk_en) begin
            irq_vector_ff <= nxt_vector;                                   // [R14]
        end
    end

    // Delayed copy of the unmaskable request, one cycle behind the live line
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmi_ff <= `IVM_RST_NMI;
        end else if (clk_en) begin
            nmi_ff <= vector_req[`IVM_VEC_NMI];                            // [R6]
        end
    end
endmodule // ivm_mapper
`default_nettype wire

// ---- dv/ivm_checker.sv ----
/* Port checker for the interrupt vector mapper.
   Assumes one clock domain and binding to ivm_mapper. */
`default_nettype none
module ivm_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        global_irq_enable,
    input wire logic        memory_scan_nonmaskable_irq,
    input wire logic [30:0] source_cond,
    input wire logic [30:0] source_clr,
    input wire logic [30:0] enable_wr,
    input wire logic [30:0] enable_val,
    input wire logic [30:0] source_pending_flag,
    input wire logic [30:0] source_irq_enable,
    input wire logic [25:0] vector_req,
    input wire logic [4:0]  irq_vector_ff,
    input wire logic        irq_valid,
    input wire logic        nmi_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    flag_set_a: assert property (clk_en && source_cond[12] |=> source_pending_flag[12])
        else $error("flag not set by condition");
    flag_clr_a: assert property (clk_en && source_clr[12] && !source_cond[12]
        |=> !source_pending_flag[12])
        else $error("flag not cleared");
    req_gate_a: assert property (vector_req[13] ==
        (global_irq_enable && source_pending_flag[12] && source_irq_enable[12]))
        else $error("vector 13 request wrong");
    global_mask_a: assert property (!global_irq_enable |->
        vector_req[25:2] == 24'h000000)
        else $error("maskable request leaked");
    nmi_pass_a: assert property (vector_req[1:0] == {memory_scan_nonmaskable_irq, 1'b0})
        else $error("vector 0 or 1 wrong");
    shared_vec_a: assert property (vector_req[8] ==
        (global_irq_enable && |(source_pending_flag[7:6] & source_irq_enable[7:6])))
        else $error("shared vector 8 wrong");
    lowest_vec_a: assert property (clk_en && vector_req[8] && vector_req[7:0] == 8'h00
        |=> irq_vector_ff == 5'h08)
        else $error("lowest vector not presented");
    freeze_hold_a: assert property (!clk_en |=> $stable(source_pending_flag))
        else $error("flags moved while frozen");
    enable_write_a: assert property (clk_en && enable_wr[12] |=>
        source_irq_enable[12] == $past(enable_val[12]))
        else $error("enable bit not written");
    valid_any_a: assert property (irq_valid == (|vector_req))
        else $error("request summary wrong");
    nmi_delay_a: assert property (clk_en |=> nmi_ff == $past(vector_req[1]))
        else $error("unmaskable flop wrong");
endmodule // ivm_checker
bind ivm_mapper ivm_checker chk (.clk, .rst_n, .clk_en, .global_irq_enable,
    .memory_scan_nonmaskable_irq, .source_cond, .source_clr, .enable_wr, .enable_val,
    .source_pending_flag, .source_irq_enable, .vector_req, .irq_vector_ff, .irq_valid,
    .nmi_ff);
`default_nettype wire

// ---- dv/ivm_periph.sv ----
/* Peripheral model: turns each raised event line into one condition pulse.
   Assumes the bench raises event lines at the falling edge. */
`default_nettype none
module ivm_periph (
    input  wire logic        clk,
    input  wire logic [30:0] fire,
    output var  logic [30:0] source_cond
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [30:0] fire_q = 31'h00000000;
    // One pulse per event, so a held line cannot re-set a cleared flag
    always @(posedge clk) begin
        fire_q      <= fire;
        source_cond <= fire & ~fire_q;
    end
endmodule // ivm_periph
`default_nettype wire

// ---- dv/ivm_mapper_tb.sv ----
/* Self-checking bench for the interrupt vector mapper.
   Assumes ivm_checker is bound and ivm_periph stands for the peripherals. */
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module ivm_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, glb = 1'b1, nmi = 1'b0;
    logic [30:0] fire = 31'h00000000, clr = 31'h00000000, wr = 31'h00000000;
    logic [30:0] val = 31'h00000000, cond, flag, ien;
    logic [25:0] req;
    logic [4:0]  vec;
    logic        valid, nmi_q;
    int          n_mismatch = 0, checks = 0, cycles = 0;
    always #2.5 clk = ~clk;
    ivm_periph per (.clk(clk), .fire(fire), .source_cond(cond));
    ivm_mapper uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .global_irq_enable(glb),
        .memory_scan_nonmaskable_irq(nmi), .source_cond(cond), .source_clr(clr),
        .enable_wr(wr), .enable_val(val), .vector_ack(1'b0), .source_pending_flag(flag),
        .source_irq_enable(ien), .vector_req(req), .irq_valid(valid), .irq_vector_ff(vec),
        .nmi_ff(nmi_q));
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task set_en(input logic [30:0] m);
        @(negedge clk) wr = m;
        val = m;
        @(negedge clk) wr = 31'h00000000;
    endtask
    // Returns once the flag has landed
    task raise(input int i);
        @(negedge clk) fire[i] = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk) fire[i] = 1'b0;
    endtask
    task lower(input int i);
        @(negedge clk) clr[i] = 1'b1;
        @(negedge clk) clr[i] = 1'b0;
    endtask
    task t_walk;
        set_en(31'h00001000);
        `CHK(ien[12], 1'b1)
        raise(12);
        `CHK(flag[12], 1'b1)
        `CHK(req, 26'h0002000)
        `CHK(valid, 1'b1)
        @(negedge clk) `CHK(vec, 5'h0D)
        lower(12);
        `CHK(req, 26'h0000000)
        `CHK(valid, 1'b0)
        $display("walk done");
    endtask
    task t_mask;
        raise(12);
        @(negedge clk) glb = 1'b0;
        nmi = 1'b1;
        clk_en = 1'b0;
        #1 `CHK(req, 26'h0000002)
        lower(12);
        `CHK(flag[12], 1'b1)
        @(negedge clk) clk_en = 1'b1;
        glb = 1'b1;
        nmi = 1'b0;
        lower(12);
        $display("mask done");
    endtask
    // Sources 25, 29 and 30 hold a flag but must raise no vector
    task t_map;
        int v;
        logic [25:0] want;
        set_en(31'h7FFFFFFF);
        for (int i = 0; i < 31; i++) begin
            v = (i > 25) ? i - 23 : (i < 6) ? i + 2 : (i < 8) ? 8 : i + 1;
            want = (i == 25 || i > 28) ? 26'h0000000 : 26'h0000001 << v;
            raise(i);
            `CHK(flag[i], 1'b1)
            `CHK(req, want)
            lower(i);
        end
        $display("map done");
    endtask
    task t_nmi;
        @(negedge clk) glb = 1'b0;
        nmi = 1'b1;
        #1 `CHK(req, 26'h0000002)
        `CHK(valid, 1'b1)
        @(negedge clk) `CHK(nmi_q, 1'b1)
        `CHK(vec, 5'h01)
        @(negedge clk) nmi = 1'b0;
        glb = 1'b1;
        #1 `CHK(valid, 1'b0)
        @(negedge clk) `CHK(nmi_q, 1'b0)
        $display("nmi done");
    endtask
    // Mid-run reset drops flags and enables; a flag alone then raises nothing
    task t_reset;
        raise(4);
        @(negedge clk) `CHK(vec, 5'h06)
        rst_n = 1'b0;
        #1 `CHK(flag, 31'h00000000)
        `CHK(ien, 31'h00000000)
        `CHK(vec, 5'h00)
        `CHK(valid, 1'b0)
        @(negedge clk) rst_n = 1'b1;
        raise(4);
        `CHK(flag[4], 1'b1)
        `CHK(req, 26'h0000000)
        lower(4);
        $display("reset done");
    endtask
    task t_prio;
        raise(19);
        raise(6);
        @(negedge clk) `CHK(vec, 5'h08)
        lower(6);
        @(negedge clk) `CHK(vec, 5'h14)
        lower(19);
        $display("prio done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        `CHK(flag, 31'h00000000)
        t_walk();
        t_mask();
        t_nmi();
        t_map();
        t_prio();
        t_reset();
        report_and_stop();
    end
endmodule // ivm_mapper_tb
`default_nettype wire
